// ===== logic/lan_board_address_decode.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// (R1) first quadrant selects local EPROM
// (R2) second quadrant selects memory-mapped I/O
// (R3) third quadrant maps to system-bus window
// (R4) top quadrant selects on-board DRAM
// (R5) window starts on any 64K boundary
// (R6) segment latch holds top eight address bits
// (R7) never answer as system-bus memory slave
// (R8) master cycles: 8/16-bit data, 24-bit address
// (R9) processor I/O stays local by default
// (R10) control write enables/disables system-bus I/O
// (R11) MMIO selected only by chip selects
// (R12) LAN DMA waits for hold grant
// (R13) read-only 48-bit station address readable
// (R14) host flag write 1 resets board
// (R15) flag 2 interrupts local CPU, 4 clears system interrupt
// (R16) flag and pointers: four host I/O ports
// (R17) host writes pointers, CPU reads them
// (R18) window address is segment shift plus offset
// (R19) board reset clears I/O enable and segment
module lan_board_address_decode #(
    parameter logic [15:0] HOST_IO_BASE = lan_decode_pkg::HOST_IO_BASE_DEF,
    parameter logic [47:0] STATION_ADDR = 48'h0000_0000_0000
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // local processor cycle and chip selects
    input wire lan_decode_pkg::cpu_req_t cpu_req_i,
    input wire logic peripheral_chip_select_i,
    input wire logic midrange_chip_select_i,
    // jumper preset for pointer 0
    input wire logic [7:0] ptr0_jumper_i,
    // LAN controller DMA request
    input wire logic lan_hold_req_i,
    input wire logic hold_grant_i,
    // host I/O write from system bus
    input wire lan_decode_pkg::host_io_t host_io_i,
    // decode results
    output lan_decode_pkg::region_t region_o,
    output logic rom_sel_o,
    output logic dram_sel_o,
    output lan_decode_pkg::sys_req_t sys_req_o,
    output logic [15:0] mmio_rdata_o,
    output logic mem_slave_sel_o,
    // DMA and control outputs
    output logic hold_req_o,
    output logic dma_go_o,
    output logic chan_attn_o,
    output logic loopback_o,
    output logic led_o,
    output logic local_int1_o,
    output logic sys_int_o,
    output logic board_reset_o
);
    import lan_decode_pkg::*;

    // ======================================================
    // synchronisers for pins from other domains
    logic [1:0] hold_s1, hold_s2, grant_s1, grant_s2;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_s1 <= 2'h0;
            hold_s2 <= 2'h0;
        end else begin
            hold_s1 <= {hold_s1[0], lan_hold_req_i};
            hold_s2 <= {hold_s2[0], hold_grant_i};
        end
    end
    assign grant_s1 = hold_s1;
    assign grant_s2 = hold_s2;
    wire hold_sync = grant_s1[1];
    wire grant_sync = grant_s2[1];

    // ======================================================
    // address decode
    function automatic region_t quadrant(input logic [LOCAL_AW-1:0] a);
        quadrant = region_t'(a[LOCAL_AW-1 -: 2]);
    endfunction

    // ======================================================
    // control state
    logic sysio_en, next_sysio_en;
    logic [SEG_W-1:0] seg, next_seg;
    logic [7:0] ptr0, ptr1, ptr2, next_ptr0, next_ptr1, next_ptr2;
    logic loop_r, next_loop_r, led_r, next_led_r, attn, next_attn;
    logic lint, next_lint, sint, next_sint, rst_req, next_rst_req;
    logic jumper_load, next_jumper_load;
    logic board_rst;
    wire cpu_wr = cpu_req_i.mem_valid && cpu_req_i.write;
    wire [2:0] pfn = cpu_req_i.addr[3:1];
    wire pcs_wr = cpu_wr && peripheral_chip_select_i &&
        quadrant(cpu_req_i.addr) == REG_MMIO; // R11
    wire host_hit = host_io_i.strobe &&
        host_io_i.addr[15:2] == HOST_IO_BASE[15:2]; // R16
    wire [1:0] host_reg = host_io_i.addr[1:0];

    // next values of local control and host-facing registers
    always_comb begin
        next_sysio_en = sysio_en;
        next_seg = seg;
        next_ptr0 = ptr0;
        next_ptr1 = ptr1;
        next_ptr2 = ptr2;
        next_loop_r = loop_r;
        next_led_r = led_r;
        next_attn = 1'b0;
        next_lint = lint;
        next_sint = sint;
        next_rst_req = 1'b0;
        next_jumper_load = 1'b0;
        if (jumper_load) begin
            next_ptr0 = ptr0_jumper_i; // R17
        end
        if (pcs_wr) begin
            case (pfn)
                PCS_CHAN_ATTN: next_attn = 1'b1;
                PCS_LOOPBACK: next_loop_r = cpu_req_i.wdata[0];
                PCS_SYSIO_EN: next_sysio_en = cpu_req_i.wdata[0]; // R10
                PCS_SYS_INT: next_sint = cpu_req_i.wdata[0];
                PCS_LED: next_led_r = cpu_req_i.wdata[0];
                PCS_WIN_SEG: next_seg = cpu_req_i.wdata[SEG_W-1:0]; // R6
                PCS_STATION: next_lint = 1'b0; // ack local interrupt
                default: next_attn = 1'b0;
            endcase
        end
        if (host_hit) begin
            case (host_reg)
                HOST_FLAG: begin
                    if (host_io_i.data == FLAG_RESET) begin
                        next_rst_req = 1'b1; // R14
                    end
                    if (host_io_i.data == FLAG_LOCAL_INT) begin
                        next_lint = 1'b1; // R15
                    end
                    if (host_io_i.data == FLAG_CLR_INT) begin
                        next_sint = 1'b0; // R15
                    end
                end
                HOST_PTR0: next_ptr0 = host_io_i.data; // R17
                HOST_PTR1: next_ptr1 = host_io_i.data;
                HOST_PTR2: next_ptr2 = host_io_i.data;
                default: next_ptr2 = ptr2;
            endcase
        end
        if (board_rst) begin
            next_sysio_en = 1'b0; // R19
            next_seg = SEG_RESET; // R19
            next_loop_r = 1'b0;
            next_led_r = 1'b0;
            next_lint = 1'b0;
            next_sint = 1'b0;
            next_ptr1 = PTR_RESET;
            next_ptr2 = PTR_RESET;
            next_jumper_load = 1'b1;
        end
    end

    // jumper preset is loaded by a clocked step after reset release
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sysio_en <= 1'b0; // R9
            seg <= SEG_RESET;
            ptr0 <= PTR_RESET;
            ptr1 <= PTR_RESET;
            ptr2 <= PTR_RESET;
            loop_r <= 1'b0;
            led_r <= 1'b0;
            attn <= 1'b0;
            lint <= 1'b0;
            sint <= 1'b0;
            rst_req <= 1'b0;
            jumper_load <= 1'b1;
        end else begin
            sysio_en <= next_sysio_en;
            seg <= next_seg;
            ptr0 <= next_ptr0;
            ptr1 <= next_ptr1;
            ptr2 <= next_ptr2;
            loop_r <= next_loop_r;
            led_r <= next_led_r;
            attn <= next_attn;
            lint <= next_lint;
            sint <= next_sint;
            rst_req <= next_rst_req;
            jumper_load <= next_jumper_load;
        end
    end

    // board reset held for a fixed number of cycles
    board_reset_gen u_rst (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .request_i(rst_req),
        .active_o(board_rst)
    );

    // ======================================================
    // registered decode and system-bus cycle formation
    region_t region, next_region;
    sys_req_t sys_req, next_sys_req;
    logic [15:0] rdata, next_rdata;
    logic rom_sel, dram_sel, next_rom_sel, next_dram_sel;
    logic hold_r, dma_go, next_hold_r, next_dma_go;
    always_comb begin
        next_region = quadrant(cpu_req_i.addr); // R2
        next_rom_sel = cpu_req_i.mem_valid &&
            next_region == REG_EPROM; // R1
        next_dram_sel = cpu_req_i.mem_valid &&
            next_region == REG_DRAM; // R4
        next_sys_req = '0;
        next_sys_req.write = cpu_req_i.write;
        next_sys_req.word = cpu_req_i.word; // R8
        next_sys_req.wdata = cpu_req_i.wdata;
        if (cpu_req_i.mem_valid && next_region == REG_WINDOW) begin
            next_sys_req.mem_cycle = 1'b1; // R3
            // R5 R18: segment on 64K steps plus 18-bit offset
            next_sys_req.addr = ({16'h0000, seg} << SEG_SHIFT) +
                {6'h00, cpu_req_i.addr[OFFSET_W-1:0]};
        end else if (cpu_req_i.io_valid && sysio_en) begin
            next_sys_req.io_cycle = 1'b1; // R10
            next_sys_req.addr = {8'h00, cpu_req_i.addr[15:0]};
        end
        // MMIO read data: pointers on mid-range select, station on pcs
        next_rdata = 16'h0000;
        if (midrange_chip_select_i && next_region == REG_MMIO) begin
            case (cpu_req_i.addr[2:1])
                2'h0: next_rdata = {8'h00, ptr0}; // R17
                2'h1: next_rdata = {8'h00, ptr1};
                2'h2: next_rdata = {8'h00, ptr2};
                default: next_rdata = {15'h0000, sysio_en};
            endcase
        end else if (peripheral_chip_select_i && next_region == REG_MMIO &&
                     pfn == PCS_STATION) begin
            next_rdata = {8'h00, STATION_ADDR[{cpu_req_i.addr[6:4], 3'h0}
                +: 8]}; // R13
        end
        next_hold_r = hold_sync; // R12
        next_dma_go = hold_sync && grant_sync; // R12
        if (board_rst) begin
            next_sys_req = '0;
            next_hold_r = 1'b0;
            next_dma_go = 1'b0;
        end
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            region <= REG_EPROM;
            rom_sel <= 1'b0;
            dram_sel <= 1'b0;
            sys_req <= '0;
            rdata <= 16'h0000;
            hold_r <= 1'b0;
            dma_go <= 1'b0;
        end else begin
            region <= next_region;
            rom_sel <= next_rom_sel;
            dram_sel <= next_dram_sel;
            sys_req <= next_sys_req;
            rdata <= next_rdata;
            hold_r <= next_hold_r;
            dma_go <= next_dma_go;
        end
    end

    assign region_o = region;
    assign rom_sel_o = rom_sel;
    assign dram_sel_o = dram_sel;
    assign sys_req_o = sys_req;
    assign mmio_rdata_o = rdata;
    assign mem_slave_sel_o = 1'b0; // R7
    assign hold_req_o = hold_r;
    assign dma_go_o = dma_go;
    assign chan_attn_o = attn;
    assign loopback_o = loop_r;
    assign led_o = led_r;
    assign local_int1_o = lint;
    assign sys_int_o = sint;
    assign board_reset_o = board_rst;

    // ======================================================
    // checks
    dma_after_grant_a: assert property (@(posedge clock_i) // R12
        disable iff (!rst_b_i) $rose(dma_go) |-> $past(grant_sync))
        else $error("dma started without hold grant");
    no_slave_a: assert property (@(posedge clock_i) // R7
        disable iff (!rst_b_i) !mem_slave_sel_o)
        else $error("answered as memory slave");
    io_gated_a: assert property (@(posedge clock_i) // R9
        disable iff (!rst_b_i) sys_req.io_cycle |-> $past(sysio_en))
        else $error("system io cycle while disabled");
    win_addr_a: assert property (@(posedge clock_i) // R18
        disable iff (!rst_b_i) sys_req.mem_cycle |->
        8'(sys_req.addr[23:16] - $past(seg)) ==
        {6'h00, $past(cpu_req_i.addr[17:16])})
        else $error("window address below segment");
    reset_clear_a: assert property (@(posedge clock_i) // R19
        disable iff (!rst_b_i) board_rst |=> (!sysio_en && seg == 8'h00))
        else $error("board reset left io enable or segment");
    flag_reset_a: assert property (@(posedge clock_i) // R14
        disable iff (!rst_b_i) (host_hit && host_reg == HOST_FLAG &&
        host_io_i.data == FLAG_RESET) |=> ##1 board_rst)
        else $error("flag 1 did not reset board");
    flag_int_a: assert property (@(posedge clock_i) // R15
        disable iff (!rst_b_i) (host_hit && host_reg == HOST_FLAG &&
        host_io_i.data == FLAG_LOCAL_INT && !board_rst) |=> lint)
        else $error("flag 2 did not interrupt");
    rom_dec_a: assert property (@(posedge clock_i) // R1
        disable iff (!rst_b_i) rom_sel |-> region == REG_EPROM)
        else $error("rom select outside first quadrant");
endmodule
`default_nettype wire

// ===== logic/lan_decode_pkg.sv
`default_nettype none
package lan_decode_pkg;
    // local processor space: 20-bit address, four quadrants
    localparam int LOCAL_AW = 20;
    localparam int SYS_AW = 24;
    localparam int OFFSET_W = 18;
    localparam int SEG_W = 8;
    localparam int SEG_SHIFT = 16;
    localparam logic [1:0] QUAD_EPROM = 2'h0;
    localparam logic [1:0] QUAD_MMIO = 2'h1;
    localparam logic [1:0] QUAD_WINDOW = 2'h2;
    localparam logic [1:0] QUAD_DRAM = 2'h3;
    // peripheral chip-select sub-functions (low address bits 3:1)
    localparam logic [2:0] PCS_CHAN_ATTN = 3'h0;
    localparam logic [2:0] PCS_STATION = 3'h1;
    localparam logic [2:0] PCS_LOOPBACK = 3'h2;
    localparam logic [2:0] PCS_SYSIO_EN = 3'h3;
    localparam logic [2:0] PCS_SYS_INT = 3'h4;
    localparam logic [2:0] PCS_LED = 3'h5;
    localparam logic [2:0] PCS_WIN_SEG = 3'h6;
    // host-side flag byte port and pointers, four consecutive I/O ports
    localparam logic [1:0] HOST_FLAG = 2'h0;
    localparam logic [1:0] HOST_PTR0 = 2'h1;
    localparam logic [1:0] HOST_PTR1 = 2'h2;
    localparam logic [1:0] HOST_PTR2 = 2'h3;
    localparam logic [7:0] FLAG_RESET = 8'h01;
    localparam logic [7:0] FLAG_LOCAL_INT = 8'h02;
    localparam logic [7:0] FLAG_CLR_INT = 8'h04;
    localparam logic [7:0] SEG_RESET = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [15:0] HOST_IO_BASE_DEF = 16'h0080;
    // board reset pulse length
    localparam int BOARD_RESET_NS = 1000;
    localparam int CLOCK_NS = 100;
    localparam int BOARD_RESET_CYC = BOARD_RESET_NS / CLOCK_NS;

    typedef enum logic [1:0] {
        REG_EPROM = 2'b00,
        REG_MMIO = 2'b01,
        REG_WINDOW = 2'b10,
        REG_DRAM = 2'b11
    } region_t;

    // local processor cycle request
    typedef struct packed {
        logic mem_valid;
        logic io_valid;
        logic write;
        logic [LOCAL_AW-1:0] addr;
        logic [15:0] wdata;
        logic word;
    } cpu_req_t;

    // master cycle on the system bus
    typedef struct packed {
        logic mem_cycle;
        logic io_cycle;
        logic write;
        logic word;
        logic [SYS_AW-1:0] addr;
        logic [15:0] wdata;
    } sys_req_t;

    // host slave I/O write
    typedef struct packed {
        logic strobe;
        logic [15:0] addr;
        logic [7:0] data;
    } host_io_t;
endpackage
`default_nettype wire

// ===== logic/board_reset_gen.sv
`timescale 1ns/10ps
`default_nettype none
// stretches a board reset request into a pulse of fixed length
module board_reset_gen #(
    parameter int CYCLES = lan_decode_pkg::BOARD_RESET_CYC
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // request and held reset
    input wire logic request_i,
    output logic active_o
);
    import lan_decode_pkg::*;
    logic [7:0] count;
    logic [7:0] next_count;
    logic active;
    logic next_active;
    // count down while active; a new request restarts the count
    always_comb begin
        next_count = count;
        if (request_i) begin
            next_count = 8'(CYCLES);
        end else if (count != 8'h00) begin
            next_count = count - 8'h01;
        end
        // registered flag keeps the reset output glitch free
        next_active = (next_count != 8'h00);
    end
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= 8'h00;
            active <= 1'b0;
        end else begin
            count <= next_count;
            active <= next_active;
        end
    end
    assign active_o = active;
endmodule
`default_nettype wire

// ===== tb/host_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// host master on the system bus
// issues single-cycle I/O writes toward the board
module host_master_model (
    // clock
    input wire logic clock_i,
    // host I/O write toward the board
    output var lan_decode_pkg::host_io_t host_io_o
);
    import lan_decode_pkg::*;

    // idle: no strobe
    initial begin
        host_io_o = '0;
    end

    // one write, strobe for a single cycle; afterwards the released lines
    // show the inverse so a late sample cannot match by luck
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #10;
        host_io_o = '{strobe: 1'b1, addr: a, data: d};
        @(posedge clock_i);
        #10;
        host_io_o = '{strobe: 1'b0, addr: ~a, data: ~d};
    endtask
endmodule
`default_nettype wire

// ===== tb/lan_board_address_decode_test.sv
`timescale 1ns/10ps
`default_nettype none
module lan_board_address_decode_test;
    import lan_decode_pkg::*;

    // ==========================================
    // stimulus and observed signals
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    cpu_req_t cpu_req = '0;
    logic peripheral_chip_select = 1'b0;
    logic midrange_chip_select = 1'b0;
    logic lan_hold = 1'b0;
    logic grant = 1'b0;
    host_io_t host_io;
    region_t region;
    sys_req_t sys_req;
    logic [15:0] rdata;
    logic rom_sel, dram_sel, slave_sel, hold_req, dma_go, chan_attn;
    logic loopback, led, int1, sys_int, brd_rst;
    int error_cnt = 0;
    int n_compared = 0;
    int n;
    localparam logic [47:0] STATION = 48'h0a0b_0c0d_0e0f;

    // 100 ns clock
    always #50 clock_i = ~clock_i;

    host_master_model host (
        .clock_i(clock_i),
        .host_io_o(host_io)
    );

    lan_board_address_decode #(
        .STATION_ADDR(STATION)
    ) uut (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .cpu_req_i(cpu_req),
        .peripheral_chip_select_i(peripheral_chip_select),
        .midrange_chip_select_i(midrange_chip_select),
        .ptr0_jumper_i(8'h5a),
        .lan_hold_req_i(lan_hold),
        .hold_grant_i(grant),
        .host_io_i(host_io),
        .region_o(region),
        .rom_sel_o(rom_sel),
        .dram_sel_o(dram_sel),
        .sys_req_o(sys_req),
        .mmio_rdata_o(rdata),
        .mem_slave_sel_o(slave_sel),
        .hold_req_o(hold_req),
        .dma_go_o(dma_go),
        .chan_attn_o(chan_attn),
        .loopback_o(loopback),
        .led_o(led),
        .local_int1_o(int1),
        .sys_int_o(sys_int),
        .board_reset_o(brd_rst)
    );

    // ==========================================
    // shared helpers
    task automatic results();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step();
        @(posedge clock_i);
        #10;
    endtask

    // a wait that ran out is a mismatch and ends the run
    task automatic bound(input int lim);
        if (n >= lim) begin
            error_cnt++;
            $display("ERROR at %0t: wait ran out", $time);
            results();
        end
    endtask

    // one processor cycle; outputs are judged right after it returns
    task automatic cpu(input logic m, input logic io, input logic wr,
            input logic [19:0] a, input logic [15:0] wd,
            input logic pc, input logic mc);
        step();
        cpu_req = '{mem_valid: m, io_valid: io, write: wr, addr: a,
                    wdata: wd, word: 1'b1};
        peripheral_chip_select = pc;
        midrange_chip_select = mc;
        step();
        cpu_req = '0;
        peripheral_chip_select = 1'b0;
        midrange_chip_select = 1'b0;
    endtask

    // ==========================================
    // scenarios
    task automatic t_decode();
        for (int q = 0; q < 4; q++) begin
            cpu(1'b1, 1'b0, 1'b0, {q[1:0], 18'h00100}, 16'h0, 1'b0, 1'b0);
            check(24'(region), 24'(q));
            check(24'(rom_sel), 24'(q == 0));
            check(24'(dram_sel), 24'(q == 3));
            check(24'(sys_req.mem_cycle), 24'(q == 2));
            check(24'(slave_sel), 24'h0);
        end
    endtask

    task automatic t_window();
        cpu(1'b1, 1'b0, 1'b1, 20'h4000c, 16'h0012, 1'b1, 1'b0);
        cpu(1'b1, 1'b0, 1'b1, 20'hbfffe, 16'h1234, 1'b0, 1'b0);
        check(24'(sys_req.mem_cycle), 24'h1);
        check(sys_req.addr, 24'h15fffe);
        check(24'(sys_req.wdata), 24'h001234);
        check(24'({sys_req.write, sys_req.word}), 24'h3);
    endtask

    task automatic t_sysio();
        cpu(1'b0, 1'b1, 1'b0, 20'h0fffe, 16'h0, 1'b0, 1'b0);
        check(24'(sys_req.io_cycle), 24'h0);
        cpu(1'b1, 1'b0, 1'b1, 20'h40006, 16'h0001, 1'b1, 1'b0);
        cpu(1'b0, 1'b1, 1'b1, 20'h0fffe, 16'h00a5, 1'b0, 1'b0);
        check(24'(sys_req.io_cycle), 24'h1);
        check(24'(sys_req.addr[15:0]), 24'h00fffe);
        cpu(1'b1, 1'b0, 1'b1, 20'h40006, 16'h0000, 1'b1, 1'b0);
        cpu(1'b0, 1'b1, 1'b0, 20'h00010, 16'h0, 1'b0, 1'b0);
        check(24'(sys_req.io_cycle), 24'h0);
    endtask

    task automatic t_hold();
        step();
        lan_hold = 1'b1;
        for (n = 0; n < 8 && hold_req !== 1'b1; n++) step();
        bound(8);
        for (int i = 0; i < 4; i++) begin
            step();
            check(24'(dma_go), 24'h0);
        end
        grant = 1'b1;
        for (n = 0; n < 8 && dma_go !== 1'b1; n++) step();
        bound(8);
        lan_hold = 1'b0;
        grant = 1'b0;
        for (n = 0; n < 8 && dma_go !== 1'b0; n++) step();
        bound(8);
    endtask

    task automatic t_host();
        cpu(1'b1, 1'b0, 1'b0, 20'h40000, 16'h0, 1'b0, 1'b1);
        check(24'(rdata[7:0]), 24'h5a);
        for (int i = 1; i < 4; i++) begin
            host.io_write(16'h0080 + 16'(i), 8'(i * 17));
            cpu(1'b1, 1'b0, 1'b0, 20'(20'h40000 + 2 * (i - 1)), 16'h0,
                1'b0, 1'b1);
            check(24'(rdata[7:0]), 24'(i * 17));
        end
        // a strobe just past the four ports is not ours
        host.io_write(16'h0084, 8'h01);
        for (int i = 0; i < 14; i++) begin
            step();
            check(24'(brd_rst), 24'h0);
        end
        host.io_write(16'h0080, 8'h02);
        for (n = 0; n < 3 && int1 !== 1'b1; n++) step();
        bound(3);
        cpu(1'b1, 1'b0, 1'b1, 20'h40008, 16'h0001, 1'b1, 1'b0);
        check(24'(sys_int), 24'h1);
        host.io_write(16'h0080, 8'h04);
        for (n = 0; n < 3 && sys_int !== 1'b0; n++) step();
        bound(3);
    endtask

    task automatic t_misc();
        cpu(1'b1, 1'b0, 1'b1, 20'h40000, 16'h0, 1'b1, 1'b0);
        check(24'(chan_attn), 24'h1);
        step();
        check(24'(chan_attn), 24'h0);
        cpu(1'b1, 1'b0, 1'b1, 20'h40004, 16'h0001, 1'b1, 1'b0);
        check(24'(loopback), 24'h1);
        cpu(1'b1, 1'b0, 1'b1, 20'h4000a, 16'h0001, 1'b1, 1'b0);
        check(24'(led), 24'h1);
        cpu(1'b1, 1'b0, 1'b0, 20'h40012, 16'h0, 1'b1, 1'b0);
        check(24'(rdata), 24'(STATION[15:8]));
    endtask

    task automatic t_board_reset();
        cpu(1'b1, 1'b0, 1'b1, 20'h4000c, 16'h0033, 1'b1, 1'b0);
        cpu(1'b1, 1'b0, 1'b1, 20'h40006, 16'h0001, 1'b1, 1'b0);
        host.io_write(16'h0080, 8'h01);
        for (n = 0; n < 4 && brd_rst !== 1'b1; n++) step();
        bound(4);
        n = 1;
        while (n < 20 && brd_rst === 1'b1) begin
            step();
            if (brd_rst === 1'b1) n++;
            else break;
        end
        check(24'(n), 24'(BOARD_RESET_CYC));
        step();
        cpu(1'b1, 1'b0, 1'b0, 20'h80010, 16'h0, 1'b0, 1'b0);
        check(sys_req.addr, 24'h000010);
        cpu(1'b0, 1'b1, 1'b0, 20'h00010, 16'h0, 1'b0, 1'b0);
        check(24'(sys_req.io_cycle), 24'h0);
        check(24'({loopback, led}), 24'h0);
        cpu(1'b1, 1'b0, 1'b0, 20'h40000, 16'h0, 1'b0, 1'b1);
        check(24'(rdata[7:0]), 24'h5a);
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (5) @(posedge clock_i);
        #10;
        rst_b_i = 1'b1;
        check(24'({brd_rst, int1, sys_int}), 24'h0);
        t_decode();
        t_window();
        t_sysio();
        t_hold();
        t_host();
        t_misc();
        t_board_reset();
        results();
    end
endmodule
`default_nettype wire
